// ---- shared/qmc_pkg.sv ----
// constants, field layouts and carrier types of the iq correction stage
// assumes one 40 MHz sample clock and an 8-bit register port
package qmc_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_GAIN_A_LO = 8'h0c;
  localparam logic [7:0] ADDR_GAIN_B_LO = 8'h0d;
  localparam logic [7:0] ADDR_PHASE_LO = 8'h0e;
  localparam logic [7:0] ADDR_UPPER = 8'h0f;
  localparam logic [7:0] ADDR_OFF_A_LO = 8'h10;
  localparam logic [7:0] ADDR_OFF_B_LO = 8'h11;
  localparam logic [7:0] ADDR_OFF_A_HI = 8'h12;
  localparam logic [7:0] ADDR_OFF_B_HI = 8'h13;
  localparam logic [7:0] ADDR_CONST_LO = 8'h14;
  localparam logic [7:0] ADDR_CONST_HI = 8'h15;
  localparam logic [7:0] ADDR_SYNC_SEL = 8'h16;
  localparam logic [7:0] ADDR_FIFO_SYNC = 8'h17;
  localparam logic [7:0] ADDR_CTRL = 8'h1e;
  localparam logic [7:0] ADDR_STATUS = 8'h1f;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_UPPER = 8'h24;
  localparam logic [7:0] RST_SYNC_SEL = 8'h15;
  localparam logic [7:0] RST_FIFO_SYNC = 8'h15;

  // ==========================================================
  // field positions
  localparam int UP_PHASE_LSB = 6;
  localparam int UP_GAIN_A_LSB = 3;
  localparam int UP_GAIN_B_LSB = 0;
  localparam int SEL_NCO_LSB = 6;
  localparam int SEL_NCO_REG_LSB = 4;
  localparam int SEL_CORR_LSB = 2;
  localparam int SEL_OFF_LSB = 0;
  localparam int FIFO_SEL_LSB = 3;
  localparam int AFLAG_SEL_BIT = 2;
  localparam int CTRL_CONST_EN_BIT = 0;
  localparam int CTRL_SIF_SYNC_BIT = 1;
  localparam int OFF_HI_W = 5;

  // ==========================================================
  // datapath widths and scaling
  localparam int SAMP_W = 16;
  localparam int GAIN_W = 11;
  localparam int GAIN_FRAC = 10;
  localparam int PHASE_W = 10;
  localparam int PHASE_SHIFT = 12;
  localparam int OFF_W = 13;
  localparam int TERM_W = 18;

  // ==========================================================
  // sync source codes
  localparam logic [1:0] SRC_TXEN = 2'b00;
  localparam logic [1:0] SRC_SYNC = 2'b01;
  localparam logic [1:0] SRC_SIF = 2'b10;
  localparam logic [1:0] SRC_ZERO = 2'b11;
  localparam logic [2:0] FSRC_TXEN = 3'h0;
  localparam logic [2:0] FSRC_SYNC = 3'h1;
  localparam logic [2:0] FSRC_SIF = 3'h2;
  localparam logic [2:0] FSRC_MSB_A = 3'h4;
  localparam logic [2:0] FSRC_MSB_B = 3'h5;
  localparam logic [2:0] FSRC_ONE = 3'h7;

  typedef enum logic [1:0] {
    MSB_ARMED = 2'b01,
    MSB_FIRED = 2'b10
  } qmc_msb_st_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } qmc_reg_req_t;

  typedef struct packed {
    logic [SAMP_W-1:0] i;
    logic [SAMP_W-1:0] q;
  } qmc_pair_t;

endpackage

// ---- logic/qmc_sync_pick.sv ----
// one 2-bit sync source selector
// assumes all sources are synchronous to the sample clock
`timescale 1ns/1ps
`default_nettype none
module qmc_sync_pick
  import qmc_pkg::*;
(
  input wire logic [1:0] i_sel,
  input wire logic i_txen,
  input wire logic i_sync,
  input wire logic i_sif,
  output logic o_sync
);

  // ==========================================================
  // source selection
  always_comb
  begin
    case (i_sel)
      SRC_TXEN: o_sync = i_txen;
      SRC_SYNC: o_sync = i_sync;
      SRC_SIF: o_sync = i_sif;
      SRC_ZERO: o_sync = 1'b0;
      default: o_sync = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// ---- logic/qmc_lane.sv ----
// one channel lane: gain, added correction term, offset, saturation
// assumes signed samples and an unsigned gain word
`timescale 1ns/1ps
`default_nettype none
module qmc_lane #(
  parameter int IN_W = 16,
  parameter int G_W = 11,
  parameter int G_FRAC = 10,
  parameter int O_W = 13,
  parameter int A_W = 18
)(
  input wire logic [IN_W-1:0] i_x,
  input wire logic [G_W-1:0] i_gain,
  input wire logic [A_W-1:0] i_add,
  input wire logic [O_W-1:0] i_off,
  output logic [A_W-1:0] o_gained,
  output logic [IN_W-1:0] o_result,
  output logic o_clip
);

  localparam int P_W = IN_W + G_W + 1;
  localparam int S_W = A_W + 2;
  localparam logic signed [S_W-1:0] MAXV = S_W'((2 ** (IN_W - 1)) - 1);
  localparam logic signed [S_W-1:0] MINV = S_W'(-(2 ** (IN_W - 1)));

  logic signed [P_W-1:0] prod;
  logic signed [S_W-1:0] sum;

  // ==========================================================
  // gain, sum and clamp
  always_comb
  begin
    prod = $signed(i_x) * $signed({1'b0, i_gain});
    o_gained = prod[G_FRAC +: A_W];
    sum = $signed({{2{o_gained[A_W-1]}}, o_gained})
      + $signed({{2{i_add[A_W-1]}}, i_add})
      + $signed({{(S_W-O_W){i_off[O_W-1]}}, i_off});
    o_clip = (sum > MAXV) || (sum < MINV);
    if (sum > MAXV)
      o_result = {1'b0, {(IN_W-1){1'b1}}};
    else if (sum < MINV)
      o_result = {1'b1, {(IN_W-1){1'b0}}};
    else
      o_result = sum[IN_W-1:0];
  end

endmodule
`default_nettype wire

// ---- logic/qmc_core.sv ----
// iq modulator correction stage with register port and sync routing
// assumes register port and samples synchronous to i_mclk
`timescale 1ns/1ps
`default_nettype none
module qmc_core
  import qmc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire qmc_reg_req_t i_reg,
  output logic [7:0] o_rdata,
  input wire qmc_pair_t i_samp,
  output qmc_pair_t o_dac,
  input wire logic i_transmit_gate_signal,
  input wire logic i_sync_pin,
  input wire logic i_fifo_txen,
  input wire logic i_fifo_sync,
  output logic o_fifo_sync,
  output logic o_a_flag,
  output logic o_nco_sync,
  output logic o_nco_load
);

  // ==========================================================
  // register storage
  logic [7:0] gain_a_low;
  logic [7:0] iq_gain_b_low;
  logic [7:0] iq_phase_low;
  logic [7:0] iq_phase_gain_upper;
  logic [7:0] offset_a_low;
  logic [7:0] offset_b_low;
  logic [7:0] offset_a_high;
  logic [7:0] offset_b_high;
  logic [7:0] constant_value_low;
  logic [7:0] constant_value_high;
  logic [7:0] sync_source_select;
  logic [7:0] fifo_sync_config;
  logic const_en;
  logic sif_sync;
  logic wr_fifo_cfg;

  assign wr_fifo_cfg = i_reg.wr && (i_reg.addr == ADDR_FIFO_SYNC);

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      gain_a_low <= RST_ZERO;
      iq_gain_b_low <= RST_ZERO;
      iq_phase_low <= RST_ZERO;
      iq_phase_gain_upper <= RST_UPPER;
      offset_a_low <= RST_ZERO;
      offset_b_low <= RST_ZERO;
      offset_a_high <= RST_ZERO;
      offset_b_high <= RST_ZERO;
      constant_value_low <= RST_ZERO;
      constant_value_high <= RST_ZERO;
      sync_source_select <= RST_SYNC_SEL;
      fifo_sync_config <= RST_FIFO_SYNC;
      const_en <= 1'b0;
    end
    else if (i_reg.wr)
    begin
      case (i_reg.addr)
        ADDR_GAIN_A_LO: gain_a_low <= i_reg.wdata;
        ADDR_GAIN_B_LO: iq_gain_b_low <= i_reg.wdata;
        ADDR_PHASE_LO: iq_phase_low <= i_reg.wdata;
        ADDR_UPPER: iq_phase_gain_upper <= i_reg.wdata;
        ADDR_OFF_A_LO: offset_a_low <= i_reg.wdata;
        ADDR_OFF_B_LO: offset_b_low <= i_reg.wdata;
        ADDR_OFF_A_HI: offset_a_high <= {3'h0, i_reg.wdata[OFF_HI_W-1:0]};
        ADDR_OFF_B_HI: offset_b_high <= {3'h0, i_reg.wdata[OFF_HI_W-1:0]};
        ADDR_CONST_LO: constant_value_low <= i_reg.wdata;
        ADDR_CONST_HI: constant_value_high <= i_reg.wdata;
        ADDR_SYNC_SEL: sync_source_select <= i_reg.wdata;
        ADDR_FIFO_SYNC: fifo_sync_config <= i_reg.wdata;
        ADDR_CTRL: const_en <= i_reg.wdata[CTRL_CONST_EN_BIT];
        default: const_en <= const_en;
      endcase
    end
  end

  // one-cycle sync pulse issued through the register port
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      sif_sync <= 1'b0;
    else
      sif_sync <= i_reg.wr && (i_reg.addr == ADDR_CTRL) && i_reg.wdata[CTRL_SIF_SYNC_BIT];
  end

  // ==========================================================
  // assembled correction words
  logic [GAIN_W-1:0] gain_a_word;
  logic [GAIN_W-1:0] gain_b_word;
  logic [PHASE_W-1:0] phase_word;
  logic [OFF_W-1:0] off_a_word;
  logic [OFF_W-1:0] off_b_word;
  logic [SAMP_W-1:0] const_word;

  assign gain_a_word = {iq_phase_gain_upper[UP_GAIN_A_LSB +: 3], gain_a_low};
  assign gain_b_word = {iq_phase_gain_upper[UP_GAIN_B_LSB +: 3], iq_gain_b_low};
  assign phase_word = {iq_phase_gain_upper[UP_PHASE_LSB +: 2], iq_phase_low};
  assign off_a_word = {offset_a_high[OFF_HI_W-1:0], offset_a_low};
  assign off_b_word = {offset_b_high[OFF_HI_W-1:0], offset_b_low};
  assign const_word = {constant_value_high, constant_value_low};

  // ==========================================================
  // sync source routing
  logic sel_nco;
  logic sel_nco_reg;
  logic corr_load;
  logic off_load;

  qmc_sync_pick u_pick_nco (
    .i_sel(sync_source_select[SEL_NCO_LSB +: 2]),
    .i_txen(i_fifo_txen),
    .i_sync(i_fifo_sync),
    .i_sif(sif_sync),
    .o_sync(sel_nco)
  );

  qmc_sync_pick u_pick_nco_reg (
    .i_sel(sync_source_select[SEL_NCO_REG_LSB +: 2]),
    .i_txen(i_fifo_txen),
    .i_sync(i_fifo_sync),
    .i_sif(sif_sync),
    .o_sync(sel_nco_reg)
  );

  qmc_sync_pick u_pick_corr (
    .i_sel(sync_source_select[SEL_CORR_LSB +: 2]),
    .i_txen(i_fifo_txen),
    .i_sync(i_fifo_sync),
    .i_sif(sif_sync),
    .o_sync(corr_load)
  );

  qmc_sync_pick u_pick_off (
    .i_sel(sync_source_select[SEL_OFF_LSB +: 2]),
    .i_txen(i_fifo_txen),
    .i_sync(i_fifo_sync),
    .i_sif(sif_sync),
    .o_sync(off_load)
  );

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_nco_sync <= 1'b0;
      o_nco_load <= 1'b0;
    end
    else
    begin
      o_nco_sync <= sel_nco;
      o_nco_load <= sel_nco_reg;
    end
  end

  // ==========================================================
  // shadow to active transfer
  logic [GAIN_W-1:0] act_gain_a;
  logic [GAIN_W-1:0] act_gain_b;
  logic [PHASE_W-1:0] act_phase;
  logic [OFF_W-1:0] act_off_a;
  logic [OFF_W-1:0] act_off_b;

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      act_gain_a <= {RST_UPPER[UP_GAIN_A_LSB +: 3], RST_ZERO};
      act_gain_b <= {RST_UPPER[UP_GAIN_B_LSB +: 3], RST_ZERO};
      act_phase <= {RST_UPPER[UP_PHASE_LSB +: 2], RST_ZERO};
    end
    else if (corr_load)
    begin
      act_gain_a <= gain_a_word;
      act_gain_b <= gain_b_word;
      act_phase <= phase_word;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      act_off_a <= '0;
      act_off_b <= '0;
    end
    else if (off_load)
    begin
      act_off_a <= off_a_word;
      act_off_b <= off_b_word;
    end
  end

  // ==========================================================
  // correction datapath
  logic [TERM_W-1:0] gained_a;
  logic [TERM_W-1:0] gained_b;
  logic [TERM_W-1:0] phase_term;
  logic [SAMP_W-1:0] res_a;
  logic [SAMP_W-1:0] res_b;
  logic clip_a;
  logic clip_b;
  logic signed [TERM_W+PHASE_W-1:0] phase_prod;

  // phase step is one 4096th, giving the -0.125 to 0.12475 span
  always_comb
  begin
    phase_prod = $signed(gained_b) * $signed(act_phase);
    phase_term = {{2{phase_prod[TERM_W+PHASE_W-1]}}, phase_prod[TERM_W+PHASE_W-1:PHASE_SHIFT]};
  end

  qmc_lane #(
    .IN_W(SAMP_W),
    .G_W(GAIN_W),
    .G_FRAC(GAIN_FRAC),
    .O_W(OFF_W),
    .A_W(TERM_W)
  ) u_lane_a (
    .i_x(i_samp.i),
    .i_gain(act_gain_a),
    .i_add(phase_term),
    .i_off(act_off_a),
    .o_gained(gained_a),
    .o_result(res_a),
    .o_clip(clip_a)
  );

  qmc_lane #(
    .IN_W(SAMP_W),
    .G_W(GAIN_W),
    .G_FRAC(GAIN_FRAC),
    .O_W(OFF_W),
    .A_W(TERM_W)
  ) u_lane_b (
    .i_x(i_samp.q),
    .i_gain(act_gain_b),
    .i_add('0),
    .i_off(act_off_b),
    .o_gained(gained_b),
    .o_result(res_b),
    .o_clip(clip_b)
  );

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_dac <= '0;
    else if (const_en)
      o_dac <= '{i: const_word, q: const_word};
    else
      o_dac <= '{i: res_a, q: res_b};
  end

  // ==========================================================
  // fifo sync source with first-msb-transition capture
  qmc_msb_st_t msb_st;
  logic [2:0] fifo_sel;
  logic prev_msb_a;
  logic prev_msb_b;
  logic msb_evt_a;
  logic msb_evt_b;
  logic next_fifo_sync;

  assign fifo_sel = fifo_sync_config[FIFO_SEL_LSB +: 3];
  assign msb_evt_a = (msb_st == MSB_ARMED) && (i_samp.i[SAMP_W-1] != prev_msb_a);
  assign msb_evt_b = (msb_st == MSB_ARMED) && (i_samp.q[SAMP_W-1] != prev_msb_b);

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      prev_msb_a <= 1'b0;
      prev_msb_b <= 1'b0;
    end
    else
    begin
      prev_msb_a <= i_samp.i[SAMP_W-1];
      prev_msb_b <= i_samp.q[SAMP_W-1];
    end
  end

  // only a reset or a fresh write of the fifo config re-arms it
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      msb_st <= MSB_ARMED;
    else
    begin
      case (msb_st)
        MSB_ARMED:
          if ((fifo_sel == FSRC_MSB_A && msb_evt_a) || (fifo_sel == FSRC_MSB_B && msb_evt_b))
            msb_st <= MSB_FIRED;
        MSB_FIRED:
          if (wr_fifo_cfg)
            msb_st <= MSB_ARMED;
        default: msb_st <= MSB_ARMED;
      endcase
    end
  end

  always_comb
  begin
    case (fifo_sel)
      FSRC_TXEN: next_fifo_sync = i_transmit_gate_signal;
      FSRC_SYNC: next_fifo_sync = i_sync_pin;
      FSRC_SIF: next_fifo_sync = sif_sync;
      FSRC_MSB_A: next_fifo_sync = msb_evt_a;
      FSRC_MSB_B: next_fifo_sync = msb_evt_b;
      FSRC_ONE: next_fifo_sync = 1'b1;
      default: next_fifo_sync = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_fifo_sync <= 1'b0;
    else
      o_fifo_sync <= next_fifo_sync;
  end

  // ==========================================================
  // a-sample flag
  logic prev_txen;

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      prev_txen <= 1'b0;
      o_a_flag <= 1'b0;
    end
    else
    begin
      prev_txen <= i_transmit_gate_signal;
      if (fifo_sync_config[AFLAG_SEL_BIT])
        o_a_flag <= i_samp.q[SAMP_W-1];
      else
        o_a_flag <= i_transmit_gate_signal && !prev_txen;
    end
  end

  // ==========================================================
  // register read port
  logic [7:0] next_rdata;

  always_comb
  begin
    case (i_reg.addr)
      ADDR_GAIN_A_LO: next_rdata = gain_a_low;
      ADDR_GAIN_B_LO: next_rdata = iq_gain_b_low;
      ADDR_PHASE_LO: next_rdata = iq_phase_low;
      ADDR_UPPER: next_rdata = iq_phase_gain_upper;
      ADDR_OFF_A_LO: next_rdata = offset_a_low;
      ADDR_OFF_B_LO: next_rdata = offset_b_low;
      ADDR_OFF_A_HI: next_rdata = offset_a_high;
      ADDR_OFF_B_HI: next_rdata = offset_b_high;
      ADDR_CONST_LO: next_rdata = constant_value_low;
      ADDR_CONST_HI: next_rdata = constant_value_high;
      ADDR_SYNC_SEL: next_rdata = sync_source_select;
      ADDR_FIFO_SYNC: next_rdata = fifo_sync_config;
      ADDR_CTRL: next_rdata = {7'h00, const_en};
      ADDR_STATUS: next_rdata = {4'h0, clip_b, clip_a, msb_st == MSB_FIRED, o_fifo_sync};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_rdata <= 8'h00;
    else if (i_reg.rd)
      o_rdata <= next_rdata;
    else
      o_rdata <= 8'h00;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);

  AST_UPPER_WR: assert property (
    i_reg.wr && i_reg.addr == ADDR_UPPER |=> iq_phase_gain_upper == $past(i_reg.wdata))
    else $error("upper register write lost");

  AST_SEL_RD: assert property (
    i_reg.rd && i_reg.addr == ADDR_SYNC_SEL |=> o_rdata == $past(sync_source_select))
    else $error("sync select read mismatch");

  AST_CONST: assert property (
    const_en |=> o_dac.i == $past(const_word) && o_dac.q == $past(const_word))
    else $error("constant value not driven");

  AST_ZERO_SRC: assert property (
    sync_source_select[SEL_CORR_LSB +: 2] == SRC_ZERO |-> !corr_load)
    else $error("zero source produced a load");

  AST_HOLD: assert property (
    !corr_load ##1 !corr_load |-> $stable(act_phase) && $stable(act_gain_b))
    else $error("active correction changed without sync");

  AST_LOAD: assert property (
    corr_load |=> act_phase == $past(phase_word) && act_gain_b == $past(gain_b_word))
    else $error("correction load missed");

  AST_SAT: assert property (
    !const_en && clip_a |=> o_dac.i == 16'h7fff || o_dac.i == 16'h8000)
    else $error("channel a wrapped instead of clamping");

  AST_MSB_ONCE: assert property (
    msb_st == MSB_FIRED && fifo_sel == FSRC_MSB_A |=> !o_fifo_sync)
    else $error("second msb sync without re-arm");

  AST_ONE: assert property (
    fifo_sel == FSRC_ONE |=> o_fifo_sync)
    else $error("constant-one fifo sync low");

  AST_AFLAG: assert property (
    !fifo_sync_config[AFLAG_SEL_BIT] && $rose(i_transmit_gate_signal) |=> o_a_flag)
    else $error("a flag missed transmit gate edge");

endmodule
`default_nettype wire

// ---- dv/qmc_src_model.sv ----
// upstream baseband source: one sample pair per clock plus fifo-side sync levels
// assumes the bench commands new values at rising edges of i_mclk
`timescale 1ns/1ps
`default_nettype none
module qmc_src_model
  import qmc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic [15:0] i_i,
  input wire logic [15:0] i_q,
  input wire logic i_txen,
  input wire logic i_sync,
  output var qmc_pair_t o_samp,
  output logic o_fifo_txen,
  output logic o_fifo_sync
);
  // ==========================================================
  // launch pairs and levels on the edge, as a fifo read port would
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_samp <= '0;
      o_fifo_txen <= 1'b0;
      o_fifo_sync <= 1'b0;
    end
    else
    begin
      o_samp <= '{i: i_i, q: i_q};
      o_fifo_txen <= i_txen;
      o_fifo_sync <= i_sync;
    end
  end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench of the iq correction stage
// assumes qmc_pkg, the design and the source model are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench
  import qmc_pkg::*;
;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  qmc_reg_req_t i_reg = '0;
  logic [7:0] o_rdata;
  logic [15:0] samp_i = '0;
  logic [15:0] samp_q = '0;
  logic src_txen = 1'b0;
  logic src_sync = 1'b0;
  logic pin_txen = 1'b1;
  logic pin_sync = 1'b0;
  qmc_pair_t i_samp;
  qmc_pair_t o_dac;
  logic fifo_txen;
  logic fifo_sync;
  logic o_fifo_sync;
  logic o_a_flag;
  logic o_nco_sync;
  logic o_nco_load;
  int n_mismatch = 0;
  int samples_checked = 0;

  always #12.5 i_mclk = ~i_mclk;

  qmc_src_model i_qmc_src_model (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_i(samp_i), .i_q(samp_q),
    .i_txen(src_txen), .i_sync(src_sync), .o_samp(i_samp), .o_fifo_txen(fifo_txen), .o_fifo_sync(fifo_sync));

  qmc_core i_qmc_core (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_reg(i_reg), .o_rdata(o_rdata),
    .i_samp(i_samp), .o_dac(o_dac), .i_transmit_gate_signal(pin_txen), .i_sync_pin(pin_sync),
    .i_fifo_txen(fifo_txen), .i_fifo_sync(fifo_sync), .o_fifo_sync(o_fifo_sync), .o_a_flag(o_a_flag),
    .o_nco_sync(o_nco_sync), .o_nco_load(o_nco_load));

  // ==========================================================
  // helpers
  task automatic final_report();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_reg <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk);
    i_reg <= '0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_mclk);
    i_reg <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_mclk);
    i_reg <= '0;
    #1;
    check({8'h00, o_rdata}, {8'h00, exp});
  endtask

  // saturating reference of gain, phase and offset
  function automatic logic [15:0] sat(input longint v);
    if (v > 32767)
      return 16'h7fff;
    if (v < -32768)
      return 16'h8000;
    return v[15:0];
  endfunction

  function automatic qmc_pair_t model(input longint si, input longint sq, input longint gb,
    input longint ph, input longint oa, input longint ob);
    longint gq;
    gq = (sq * gb) >>> 10;
    model.i = sat(si + ((gq * ph) >>> 12) + oa);
    model.q = sat(gq + ob);
  endfunction

  task automatic chk_dac(input qmc_pair_t e);
    check(o_dac.i, e.i);
    check(o_dac.q, e.q);
  endtask

  task automatic fs_hits(input int n, input logic [15:0] exp);
    int hits;
    hits = 0;
    repeat (n)
    begin
      @(posedge i_mclk);
      #1;
      hits += o_fifo_sync;
    end
    check(hits[15:0], exp);
  endtask

  task automatic pulse_sync();
    @(posedge i_mclk);
    src_sync <= 1'b1;
    @(posedge i_mclk);
    src_sync <= 1'b0;
    wait_n(4);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs();
    rd_chk(ADDR_UPPER, RST_UPPER);
    rd_chk(ADDR_SYNC_SEL, RST_SYNC_SEL);
    rd_chk(ADDR_PHASE_LO, 8'h00);
    wr(ADDR_GAIN_B_LO, 8'ha5);
    rd_chk(ADDR_GAIN_B_LO, 8'ha5);
    wr(ADDR_OFF_B_HI, 8'hff);
    rd_chk(ADDR_OFF_B_HI, 8'h1f);
    wr(8'h20, 8'h5a);
    rd_chk(8'h20, 8'h00);
  endtask

  task automatic t_path();
    @(posedge i_mclk);
    samp_i <= 16'd1000;
    samp_q <= 16'd2000;
    wr(ADDR_GAIN_B_LO, 8'h00);
    wr(ADDR_PHASE_LO, 8'h00);
    wr(ADDR_UPPER, 8'he6);
    wr(ADDR_OFF_A_LO, 8'h00);
    wr(ADDR_OFF_A_HI, 8'h1f);
    wr(ADDR_OFF_B_LO, 8'h64);
    wr(ADDR_OFF_B_HI, 8'h00);
    wr(ADDR_SYNC_SEL, 8'h07);
    wait_n(3);
    chk_dac(model(1000, 2000, 1024, 0, 0, 0));
    pulse_sync();
    chk_dac(model(1000, 2000, 1536, -256, 0, 0));
    wr(ADDR_SYNC_SEL, 8'h05);
    pulse_sync();
    chk_dac(model(1000, 2000, 1536, -256, -256, 100));
    @(posedge i_mclk);
    samp_i <= 16'h7fff;
    samp_q <= 16'h8000;
    wait_n(3);
    chk_dac(model(32767, -32768, 1536, -256, -256, 100));
  endtask

  task automatic t_const();
    wr(ADDR_CONST_LO, 8'h34);
    wr(ADDR_CONST_HI, 8'h92);
    wr(ADDR_CTRL, 8'h01);
    rd_chk(ADDR_CTRL, 8'h01);
    wait_n(2);
    check(o_dac.i, 16'h9234);
    check(o_dac.q, 16'h9234);
    wr(ADDR_CTRL, 8'h00);
  endtask

  task automatic t_sync();
    logic [1:0] c;
    logic e;
    int hits;
    for (int p = 0; p < 2; p++)
    begin
      @(posedge i_mclk);
      src_txen <= (p == 0);
      src_sync <= (p == 1);
      for (int k = 0; k < 4; k++)
      begin
        c = k[1:0];
        e = (c == SRC_TXEN) ? (p == 0) : (c == SRC_SYNC) ? (p == 1) : 1'b0;
        wr(ADDR_SYNC_SEL, {c, c, 4'h5});
        if (c == SRC_SIF)
        begin
          hits = 0;
          wr(ADDR_CTRL, 8'h02);
          repeat (5)
          begin
            @(posedge i_mclk);
            #1;
            hits += o_nco_sync + o_nco_load;
          end
          check(hits[15:0], 16'h0002);
        end
        else
        begin
          wait_n(2);
          check({15'h0, o_nco_sync}, {15'h0, e});
          check({15'h0, o_nco_load}, {15'h0, e});
        end
      end
    end
  endtask

  task automatic t_fifo_sel();
    logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    logic exps [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    @(posedge i_mclk);
    pin_sync <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      wr(ADDR_FIFO_SYNC, {2'b00, codes[k], 3'b000});
      wait_n(2);
      check({15'h0, o_fifo_sync}, {15'h0, exps[k]});
    end
  endtask

  // first msb transition fires once, a config write re-arms
  task automatic t_msb();
    wr(ADDR_FIFO_SYNC, {2'b00, FSRC_MSB_A, 3'b000});
    fs_hits(3, 16'h0000);
    @(posedge i_mclk);
    samp_i <= 16'h8000;
    fs_hits(6, 16'h0001);
    @(posedge i_mclk);
    samp_i <= 16'h7fff;
    fs_hits(6, 16'h0000);
    rd_chk(ADDR_STATUS, 8'h0e);
    wr(ADDR_FIFO_SYNC, {2'b00, FSRC_MSB_B, 3'b000});
    @(posedge i_mclk);
    samp_q <= 16'h0000;
    fs_hits(6, 16'h0001);
    wr(ADDR_FIFO_SYNC, {2'b00, FSRC_SIF, 3'b000});
    wr(ADDR_CTRL, 8'h02);
    fs_hits(4, 16'h0001);
  endtask

  task automatic t_aflag();
    wr(ADDR_FIFO_SYNC, 8'h00);
    @(posedge i_mclk);
    pin_txen <= 1'b0;
    wait_n(2);
    check({15'h0, o_a_flag}, 16'h0000);
    @(posedge i_mclk);
    pin_txen <= 1'b1;
    wait_n(1);
    check({15'h0, o_a_flag}, 16'h0001);
    wait_n(1);
    check({15'h0, o_a_flag}, 16'h0000);
    wr(ADDR_FIFO_SYNC, 8'h04);
    @(posedge i_mclk);
    samp_q <= 16'h8000;
    wait_n(3);
    check({15'h0, o_a_flag}, 16'h0001);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (6) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    t_regs();
    t_path();
    t_const();
    t_sync();
    t_fifo_sel();
    t_msb();
    t_aflag();
    final_report();
  end

  initial
  begin
    repeat (5000) @(posedge i_mclk);
    n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire
